// *** hw/sensor_diag_cfg.svh ***
`ifndef SENSOR_DIAG_CFG_SVH
`define SENSOR_DIAG_CFG_SVH

// Register indexes on the programming access port.
`define IDX_W                 4
`define IDX_FAULT_FLAGS       4'h0
`define IDX_PROG_ERRORS       4'h1
`define IDX_MAKER_WORD_A      4'h2
`define IDX_MAKER_WORD_B      4'h3
`define IDX_USER_TAG_A        4'h4
`define IDX_USER_TAG_B        4'h5
`define IDX_PHASE_COEFF       4'h6
`define IDX_GAIN_FIRST        4'h7
`define IDX_GAIN_SECOND       4'h8
`define IDX_OFFSET_CONST      4'h9
`define IDX_OFFSET_LINEAR     4'hA
`define IDX_OFFSET_SQUARE     4'hB
`define IDX_SHARE_FIRST       4'hC
`define IDX_SHARE_SECOND      4'hD

// Fault flag bit positions.
`define FLT_CLAMP_HIGH        9
`define FLT_CLAMP_LOW         8
`define FLT_CLIP_FIRST        7
`define FLT_CLIP_SECOND       6
`define FLT_DSP_TEST          5
`define FLT_MEM_TEST          4
`define FLT_ROM_PARITY        3
`define FLT_FIELD_HIGH        1
`define FLT_FIELD_LOW         0

// Programming error bit positions and field masks.
`define PRG_PUMP_LOW          10
`define PRG_SUPPLY_LOW        9
`define PRG_SETUP_WRITE       8
`define PRG_CTRL_MASK         16'h003F
`define PRG_FLAG_MASK         16'h0700

// Reset values.
`define RST_ZERO              16'h0000
`define RST_UNITY_GAIN        16'h4000

// Fixed point scaling.
`define GAIN_FRAC_BITS        14
`define Q15_FRAC_BITS         15
`define TEMP_MAX              16'h7FFF

`endif

// *** hw/sensor_diag_pkg.sv ***
package sensor_diag_pkg;

  typedef logic signed [15:0] coeff_t;
  typedef logic signed [33:0] wide_t;

  // Clips a wide signed result into the 16-bit two's-complement range.
  function automatic coeff_t sat16(input wide_t v);
    if (v > 34'sh0000_7FFF) begin
      return 16'sh7FFF;
    end else if (v < -34'sh0000_8000) begin
      return -16'sh8000;
    end
    return coeff_t'(v[15:0]);
  endfunction : sat16

endpackage : sensor_diag_pkg

// *** hw/channel_trim.sv ***
`timescale 1ns/1ps
`include "sensor_diag_cfg.svh"

module channel_trim
  import sensor_diag_pkg::*;
(
  // Clock and reset
  input  wire logic   ref_clk_i,
  input  wire logic   reset_n_i,
  // Sample in
  input  wire logic   in_valid_i,
  input  wire coeff_t sample_i,
  input  wire coeff_t gain_i,
  input  wire coeff_t offset_i,
  input  wire coeff_t share_i,
  // Sample out
  output logic        out_valid_o,
  output coeff_t      sample_o
);

  logic signed [31:0] gain_prod;
  logic signed [31:0] share_prod;
  coeff_t             share_pos;
  coeff_t             gained;
  wide_t              sum;

  always_comb begin
    gain_prod = sample_i * gain_i;
    gained    = sat16(wide_t'(gain_prod >>> `GAIN_FRAC_BITS));
    // A negative share would invert the offset, so it is treated as no share.
    share_pos  = share_i[15] ? coeff_t'(`RST_ZERO) : share_i;
    share_prod = offset_i * share_pos;
    sum        = wide_t'(gained) + wide_t'(share_prod >>> `Q15_FRAC_BITS);
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_valid_o <= 1'b0;
      sample_o    <= '0;
    end else begin
      out_valid_o <= in_valid_i;
      if (in_valid_i) begin
        sample_o <= sat16(sum);
      end
    end
  end

endmodule : channel_trim

// *** hw/sensor_diag_and_channel_trim.sv ***
// Functional notes
// - Set fault bit 9 at upper clamp.
// - Set fault bit 8 at lower clamp.
// - Bits 7/6 flag first/second converter clipping.
// - Bit 5 flags failed signal processor test.
// - Bit 4 flags failed memory self test.
// - Bit 3 flags program memory parity failure.
// - Bit 1 flags field above upper limit.
// - Bit 0 flags field below lower limit.
// - Fault register 16 bits, 15:10, 2 reserved.
// - Programming error bit 10: pump voltage low.
// - Bit 9: supply low during program/erase.
// - Bit 8: setup memory write failed.
// - Bits 5:0 control programming; 15:11 reserved.
// - Two read-only maker production words.
// - Two writable user tag words.
// - Signed sine-based phase coefficient, zero neutral.
// - Signed channel gains, 16384 is unity.
// - Offset is second-order temperature polynomial.
// - Each channel adds scaled offset share.
// - Temperature input is 0 to 32767.
`timescale 1ns/1ps
`include "sensor_diag_cfg.svh"

module sensor_diag_and_channel_trim
  import sensor_diag_pkg::*;
#(
  // Production words are fixed at manufacture; these values are arbitrary.
  parameter logic [15:0] MAKER_WORD_A = 16'h1234,
  parameter logic [15:0] MAKER_WORD_B = 16'h5678
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         reset_n_i,
  // Register access from the programming decoder
  input  wire logic         reg_wr_i,
  input  wire logic         reg_rd_i,
  input  wire logic [3:0]   reg_index_i,
  input  wire logic [15:0]  reg_wdata_i,
  output logic [15:0]       reg_rdata_o,
  output logic              reg_rvalid_o,
  output logic              reg_unmapped_o,
  // Output and clamping levels
  input  wire coeff_t       output_code_i,
  input  wire coeff_t       clamp_high_level_i,
  input  wire coeff_t       clamp_low_level_i,
  // Converter and self-test events
  input  wire logic         first_clip_i,
  input  wire logic         second_clip_i,
  input  wire logic         dsp_test_fail_i,
  input  wire logic         mem_test_fail_i,
  input  wire logic         rom_parity_fail_i,
  // Magnetic range check
  input  wire coeff_t       field_magnitude_i,
  input  wire coeff_t       upper_magnetic_limit_i,
  input  wire coeff_t       lower_magnetic_limit_i,
  // Memory programming events
  input  wire logic         pump_low_i,
  input  wire logic         supply_low_i,
  input  wire logic         setup_write_fail_i,
  output logic [5:0]        prog_control_o,
  // Signal path in
  input  wire logic         sample_valid_i,
  input  wire coeff_t       first_field_channel_i,
  input  wire coeff_t       second_field_channel_i,
  input  wire logic [15:0]  junction_temperature_reading_i,
  // Signal path out
  output logic              angle_valid_o,
  output coeff_t            angle_first_o,
  output coeff_t            angle_second_o,
  output coeff_t            offset_poly_o
);

  logic [15:0] self_test_fault_flags;
  logic [15:0] programming_error_flags;
  coeff_t      user_tag_word_a;
  coeff_t      user_tag_word_b;
  coeff_t      phase_correction_coeff;
  coeff_t      first_channel_gain;
  coeff_t      second_channel_gain;
  coeff_t      offset_poly_const;
  coeff_t      offset_poly_linear;
  coeff_t      offset_poly_square;
  coeff_t      offset_share_first_channel;
  coeff_t      offset_share_second_channel;

  logic [15:0] fault_events;
  logic [15:0] prog_events;
  logic        wr_fault;
  logic        rd_fault;
  logic        wr_prog;
  logic        mapped;
  logic [15:0] next_rdata;

  // Fault events, sampled every cycle from the signal processor.
  always_comb begin
    fault_events                   = '0;
    fault_events[`FLT_CLAMP_HIGH]  = (output_code_i >= clamp_high_level_i);
    fault_events[`FLT_CLAMP_LOW]   = (output_code_i <= clamp_low_level_i);
    fault_events[`FLT_CLIP_FIRST]  = first_clip_i;
    fault_events[`FLT_CLIP_SECOND] = second_clip_i;
    fault_events[`FLT_DSP_TEST]    = dsp_test_fail_i;
    fault_events[`FLT_MEM_TEST]    = mem_test_fail_i;
    fault_events[`FLT_ROM_PARITY]  = rom_parity_fail_i;
    fault_events[`FLT_FIELD_HIGH]  = (field_magnitude_i > upper_magnetic_limit_i);
    fault_events[`FLT_FIELD_LOW]   = (field_magnitude_i < lower_magnetic_limit_i);
  end

  always_comb begin
    prog_events                   = '0;
    prog_events[`PRG_PUMP_LOW]    = pump_low_i;
    prog_events[`PRG_SUPPLY_LOW]  = supply_low_i;
    prog_events[`PRG_SETUP_WRITE] = setup_write_fail_i;
  end

  assign wr_fault = reg_wr_i && (reg_index_i == `IDX_FAULT_FLAGS);
  assign rd_fault = reg_rd_i && (reg_index_i == `IDX_FAULT_FLAGS);
  assign wr_prog  = reg_wr_i && (reg_index_i == `IDX_PROG_ERRORS);

  // Fault flags are sticky so a short fault is not missed between polls.
  // Reading clears them, but an event in the same cycle keeps its bit set.
  // The register is read-only, so writes are ignored.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      self_test_fault_flags <= `RST_ZERO;
    end else if (rd_fault) begin
      self_test_fault_flags <= fault_events;
    end else begin
      self_test_fault_flags <= self_test_fault_flags | fault_events;
    end
  end

  // Error bits clear by writing one; a new event wins over the clear.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      programming_error_flags <= `RST_ZERO;
    end else if (wr_prog) begin
      programming_error_flags <=
        (programming_error_flags & `PRG_FLAG_MASK & ~reg_wdata_i)
        | prog_events
        | (reg_wdata_i & `PRG_CTRL_MASK);
    end else begin
      programming_error_flags <= programming_error_flags | prog_events;
    end
  end

  assign prog_control_o = programming_error_flags[5:0];

  // Writable identification words.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      user_tag_word_a <= `RST_ZERO;
      user_tag_word_b <= `RST_ZERO;
    end else if (reg_wr_i) begin
      if (reg_index_i == `IDX_USER_TAG_A) begin
        user_tag_word_a <= reg_wdata_i;
      end
      if (reg_index_i == `IDX_USER_TAG_B) begin
        user_tag_word_b <= reg_wdata_i;
      end
    end
  end

  // Phase coefficient; zero leaves the second channel untouched.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_correction_coeff <= `RST_ZERO;
    end else if (reg_wr_i && (reg_index_i == `IDX_PHASE_COEFF)) begin
      phase_correction_coeff <= reg_wdata_i;
    end
  end

  // Gains start at unity so an untrimmed part passes data unscaled.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      first_channel_gain  <= `RST_UNITY_GAIN;
      second_channel_gain <= `RST_UNITY_GAIN;
    end else if (reg_wr_i) begin
      if (reg_index_i == `IDX_GAIN_FIRST) begin
        first_channel_gain <= reg_wdata_i;
      end
      if (reg_index_i == `IDX_GAIN_SECOND) begin
        second_channel_gain <= reg_wdata_i;
      end
    end
  end

  // Offset polynomial coefficients, constant term first.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      offset_poly_const  <= `RST_ZERO;
      offset_poly_linear <= `RST_ZERO;
      offset_poly_square <= `RST_ZERO;
    end else if (reg_wr_i) begin
      if (reg_index_i == `IDX_OFFSET_CONST) begin
        offset_poly_const <= reg_wdata_i;
      end
      if (reg_index_i == `IDX_OFFSET_LINEAR) begin
        offset_poly_linear <= reg_wdata_i;
      end
      if (reg_index_i == `IDX_OFFSET_SQUARE) begin
        offset_poly_square <= reg_wdata_i;
      end
    end
  end

  // Offset shares start at zero, so no offset reaches a channel until chosen.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      offset_share_first_channel  <= `RST_ZERO;
      offset_share_second_channel <= `RST_ZERO;
    end else if (reg_wr_i) begin
      if (reg_index_i == `IDX_SHARE_FIRST) begin
        offset_share_first_channel <= reg_wdata_i;
      end
      if (reg_index_i == `IDX_SHARE_SECOND) begin
        offset_share_second_channel <= reg_wdata_i;
      end
    end
  end

  // Read multiplexer; unmapped indexes read zero and raise the unmapped pulse.
  // Reserved flag bits are never set by the flag logic, so they read zero.
  always_comb begin
    mapped     = 1'b1;
    next_rdata = '0;
    case (reg_index_i)
      `IDX_FAULT_FLAGS:   next_rdata = self_test_fault_flags;
      `IDX_PROG_ERRORS:   next_rdata = programming_error_flags;
      `IDX_MAKER_WORD_A:  next_rdata = MAKER_WORD_A;
      `IDX_MAKER_WORD_B:  next_rdata = MAKER_WORD_B;
      `IDX_USER_TAG_A:    next_rdata = user_tag_word_a;
      `IDX_USER_TAG_B:    next_rdata = user_tag_word_b;
      `IDX_PHASE_COEFF:   next_rdata = phase_correction_coeff;
      `IDX_GAIN_FIRST:    next_rdata = first_channel_gain;
      `IDX_GAIN_SECOND:   next_rdata = second_channel_gain;
      `IDX_OFFSET_CONST:  next_rdata = offset_poly_const;
      `IDX_OFFSET_LINEAR: next_rdata = offset_poly_linear;
      `IDX_OFFSET_SQUARE: next_rdata = offset_poly_square;
      `IDX_SHARE_FIRST:   next_rdata = offset_share_first_channel;
      `IDX_SHARE_SECOND:  next_rdata = offset_share_second_channel;
      default:            mapped     = 1'b0;
    endcase
  end

  // Read data holds between reads so a slow programmer may sample it late.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o    <= '0;
      reg_rvalid_o   <= 1'b0;
      reg_unmapped_o <= 1'b0;
    end else begin
      reg_rvalid_o   <= reg_rd_i;
      reg_unmapped_o <= reg_rd_i && !mapped;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  // Temperature dependent offset: c0 + c1*t + c2*t*t, t in Q15 full scale.
  // Bit 15 of the reading is never used, so it is dropped here.
  coeff_t             temp_q15;
  logic signed [31:0] temp_sq_prod;
  coeff_t             temp_sq;
  logic signed [31:0] lin_prod;
  logic signed [31:0] sq_prod;
  wide_t              poly_sum;

  always_comb begin
    temp_q15     = coeff_t'({1'b0, junction_temperature_reading_i[14:0]});
    temp_sq_prod = temp_q15 * temp_q15;
    temp_sq      = coeff_t'(temp_sq_prod >>> `Q15_FRAC_BITS);
    lin_prod     = offset_poly_linear * temp_q15;
    sq_prod      = offset_poly_square * temp_sq;
    poly_sum     = wide_t'(offset_poly_const)
                 + wide_t'(lin_prod >>> `Q15_FRAC_BITS)
                 + wide_t'(sq_prod >>> `Q15_FRAC_BITS);
  end

  // Phase stage: the second channel takes a sine-weighted part of the first.
  // Its gain must be raised by the programmer to undo the cosine loss.
  logic signed [31:0] phase_prod;
  wide_t              phase_sum;

  always_comb begin
    phase_prod = first_field_channel_i * phase_correction_coeff;
    phase_sum  = wide_t'(second_field_channel_i)
               + wide_t'(phase_prod >>> `Q15_FRAC_BITS);
  end

  logic   stage_valid;
  coeff_t stage_first;
  coeff_t stage_second;
  coeff_t stage_offset;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage_valid  <= 1'b0;
      stage_first  <= '0;
      stage_second <= '0;
      stage_offset <= '0;
    end else begin
      stage_valid <= sample_valid_i;
      if (sample_valid_i) begin
        stage_first  <= first_field_channel_i;
        stage_second <= sat16(phase_sum);
        stage_offset <= sat16(poly_sum);
      end
    end
  end

  assign offset_poly_o = stage_offset;

  // Both channels take the same offset, each scaled by its own share.
  channel_trim u_trim_first (
    .ref_clk_i   (ref_clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (stage_valid),
    .sample_i    (stage_first),
    .gain_i      (first_channel_gain),
    .offset_i    (stage_offset),
    .share_i     (offset_share_first_channel),
    .out_valid_o (angle_valid_o),
    .sample_o    (angle_first_o)
  );

  // Its valid equals the first channel's, so that output is left open.
  channel_trim u_trim_second (
    .ref_clk_i   (ref_clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (stage_valid),
    .sample_i    (stage_second),
    .gain_i      (second_channel_gain),
    .offset_i    (stage_offset),
    .share_i     (offset_share_second_channel),
    .out_valid_o (),
    .sample_o    (angle_second_o)
  );

endmodule : sensor_diag_and_channel_trim

// *** tb/sensor_diag_chk.sv ***
`timescale 1ns/1ps
module sensor_diag_chk
  import sensor_diag_pkg::*;
#(
  parameter logic [15:0] MAKER_WORD_A = 16'h1234
) (
  // Clock and register port
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [3:0]  reg_index_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        reg_unmapped_o,
  // Event sources and programming control
  input wire coeff_t      output_code_i,
  input wire coeff_t      clamp_high_level_i,
  input wire logic        first_clip_i,
  input wire coeff_t      field_magnitude_i,
  input wire coeff_t      lower_magnetic_limit_i,
  input wire logic        pump_low_i,
  input wire logic [5:0]  prog_control_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // A read shows what was latched before its own edge, so each event leads its read by a cycle.
  a_clamp_high_flag:
    assert property ((output_code_i >= clamp_high_level_i) ##1 (reg_rd_i && reg_index_i == 4'h0)
      |=> reg_rdata_o[9]) else $error("clamp high flag missing");
  a_clip_first_flag:
    assert property (first_clip_i ##1 (reg_rd_i && reg_index_i == 4'h0) |=> reg_rdata_o[7])
      else $error("first clip flag missing");
  a_field_low_flag:
    assert property ((field_magnitude_i < lower_magnetic_limit_i) ##1
      (reg_rd_i && reg_index_i == 4'h0) |=> reg_rdata_o[0]) else $error("weak field flag missing");
  a_fault_spare_zero:
    assert property (reg_rd_i && reg_index_i == 4'h0 |=> reg_rdata_o[15:10] == 6'h00
      && !reg_rdata_o[2]) else $error("fault spare bits not zero");
  a_pump_low_flag:
    assert property (pump_low_i ##1 (reg_rd_i && reg_index_i == 4'h1) |=> reg_rdata_o[10])
      else $error("pump low flag missing");
  property p_ctrl_write;
    logic [5:0] v;
    (reg_wr_i && reg_index_i == 4'h1, v = reg_wdata_i[5:0]) |=> prog_control_o == v;
  endproperty
  a_ctrl_write_lands:
    assert property (p_ctrl_write) else $error("control bits not written");
  a_prog_read_view:
    assert property (reg_rd_i && reg_index_i == 4'h1 && !reg_wr_i |=> reg_rdata_o[5:0] ==
      prog_control_o && reg_rdata_o[15:11] == 5'h00 && reg_rdata_o[7:6] == 2'h0)
      else $error("programming word read wrong");
  a_maker_word_fixed:
    assert property (reg_rd_i && reg_index_i == 4'h2 |=> reg_rdata_o == MAKER_WORD_A)
      else $error("maker word changed");
  a_unmapped_zero:
    assert property (reg_rd_i && reg_index_i > 4'hD |=> reg_unmapped_o && reg_rdata_o == 16'h0000)
      else $error("unmapped read wrong");

  cover property (reg_unmapped_o);
  cover property (pump_low_i ##1 (reg_rd_i && reg_index_i == 4'h1));
  cover property (reg_wr_i && reg_index_i == 4'h1);
endmodule : sensor_diag_chk

bind sensor_diag_and_channel_trim sensor_diag_chk #(.MAKER_WORD_A(MAKER_WORD_A))
  i_sensor_diag_chk (.ref_clk_i, .reset_n_i, .reg_wr_i, .reg_rd_i, .reg_index_i,
  .reg_wdata_i, .reg_rdata_o, .reg_unmapped_o, .output_code_i, .clamp_high_level_i,
  .first_clip_i, .field_magnitude_i, .lower_magnetic_limit_i, .pump_low_i, .prog_control_o);

// *** tb/sensor_programmer.sv ***
`timescale 1ns/1ps
module sensor_programmer (
  // Clock
  input  wire logic        ref_clk_i,
  // Register port towards the device
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic [3:0]       reg_index_o,
  output logic [15:0]      reg_wdata_o,
  input  wire logic [15:0] reg_rdata_i,
  input  wire logic        reg_rvalid_i,
  input  wire logic        reg_unmapped_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_index_o = 4'hF;
    reg_wdata_o = 16'h0000;
  end
  // Between writes the data lines carry the inverse word, so stray latching shows up.
  task automatic write_reg(input logic [3:0] idx, input logic [15:0] data);
    @(posedge ref_clk_i) #1;
    reg_wr_o = 1'b1;
    reg_index_o = idx;
    reg_wdata_o = data;
    @(posedge ref_clk_i) #1;
    reg_wr_o = 1'b0;
    reg_wdata_o = ~data;
  endtask : write_reg
  // The answer comes one cycle after the strobe; a missing answer returns unknown.
  task automatic read_reg(input logic [3:0] idx, output logic [15:0] data, output logic unm);
    data = 'x;
    unm = 1'bx;
    @(posedge ref_clk_i) #1;
    reg_rd_o = 1'b1;
    reg_index_o = idx;
    @(posedge ref_clk_i) #1;
    reg_rd_o = 1'b0;
    if (reg_rvalid_i === 1'b1) begin
      data = reg_rdata_i;
      unm = reg_unmapped_i;
    end
  endtask : read_reg
endmodule : sensor_programmer

// *** tb/sensor_diag_and_channel_trim_tb.sv ***
`timescale 1ns/1ps
module sensor_diag_and_channel_trim_tb;
  import sensor_diag_pkg::*;
  // Production words are arbitrary values.
  localparam logic [15:0] WORD_A = 16'h2C4B;
  localparam logic [15:0] WORD_B = 16'h71E6;
  logic        ref_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        reg_wr_i, reg_rd_i, reg_unmapped_o, reg_rvalid_o, angle_valid_o;
  logic        sample_valid_i = 1'b0;
  logic [3:0]  reg_index_i;
  logic [15:0] reg_wdata_i, reg_rdata_o;
  logic [15:0] junction_temperature_reading_i = 16'h0000;
  logic [5:0]  prog_control_o;
  logic [8:0]  ev = '0;
  logic [2:0]  pev = '0;
  coeff_t      first_field_channel_i = '0;
  coeff_t      second_field_channel_i = '0;
  coeff_t      angle_first_o, angle_second_o, offset_poly_o;
  int          failures = 0;
  int          checked = 0;

  always #12.5 ref_clk_i = ~ref_clk_i;

  sensor_diag_and_channel_trim #(.MAKER_WORD_A(WORD_A), .MAKER_WORD_B(WORD_B))
    i_sensor_diag_and_channel_trim (.ref_clk_i, .reset_n_i, .reg_wr_i, .reg_rd_i,
    .reg_index_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .reg_unmapped_o,
    .output_code_i(ev[0] ? 16'sh03E8 : (ev[1] ? 16'shFC18 : 16'sh0000)),
    .clamp_high_level_i(16'sh03E8), .clamp_low_level_i(16'shFC18), .first_clip_i(ev[2]),
    .second_clip_i(ev[3]), .dsp_test_fail_i(ev[4]), .mem_test_fail_i(ev[5]),
    .rom_parity_fail_i(ev[6]),
    .field_magnitude_i(ev[7] ? 16'sh03E9 : (ev[8] ? 16'shFC17 : 16'sh0000)),
    .upper_magnetic_limit_i(16'sh03E8), .lower_magnetic_limit_i(16'shFC18),
    .pump_low_i(pev[0]), .supply_low_i(pev[1]), .setup_write_fail_i(pev[2]),
    .prog_control_o, .sample_valid_i, .first_field_channel_i, .second_field_channel_i,
    .junction_temperature_reading_i, .angle_valid_o, .angle_first_o, .angle_second_o,
    .offset_poly_o);

  sensor_programmer i_sensor_programmer (.ref_clk_i, .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_index_o(reg_index_i), .reg_wdata_o(reg_wdata_i),
    .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o), .reg_unmapped_i(reg_unmapped_o));

  task automatic give_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rd(input logic [3:0] idx, input logic [15:0] exp, input logic exp_u = 1'b0);
    logic [15:0] d;
    logic        u;
    i_sensor_programmer.read_reg(idx, d, u);
    if (u === 1'bx) begin
      failures++;
      give_verdict;
    end else begin
      chk(d, exp);
      chk({15'h0000, u}, {15'h0000, exp_u});
    end
  endtask : rd

  task automatic t_reset;
    for (int i = 0; i < 16; i++) begin
      rd(4'(i), (i == 2) ? WORD_A : ((i == 3) ? WORD_B : ((i == 7 || i == 8) ? 16'h4000
        : 16'h0000)), i > 13);
    end
    $display("reset value test done");
  endtask : t_reset

  task automatic t_access;
    for (int i = 0; i < 14; i++) begin
      if (i != 1) i_sensor_programmer.write_reg(4'(i), 16'hA5C3 ^ 16'(i));
    end
    for (int i = 2; i < 14; i++) begin
      rd(4'(i), (i == 2) ? WORD_A : ((i == 3) ? WORD_B : 16'hA5C3 ^ 16'(i)));
    end
    rd(4'h0, 16'h0000);
    $display("access test done");
  endtask : t_access

  task automatic t_faults;
    int fbit [9] = '{9, 8, 7, 6, 5, 4, 3, 1, 0};
    for (int k = 0; k < 9; k++) begin
      ev = 9'(1 << k);
      rd(4'h0, 16'(1 << fbit[k]));
      ev = '0;
      rd(4'h0, 16'(1 << fbit[k]));
      rd(4'h0, 16'h0000);
    end
    $display("fault flag test done");
  endtask : t_faults

  task automatic t_prog;
    for (int k = 0; k < 3; k++) begin
      pev = 3'(1 << k);
      rd(4'h1, (16'h0400 >> k) | ((k == 0) ? 16'h0000 : 16'(k + 4)));
      pev = '0;
      rd(4'h1, (16'h0400 >> k) | ((k == 0) ? 16'h0000 : 16'(k + 4)));
      i_sensor_programmer.write_reg(4'h1, 16'hF8C0 | (16'h0400 >> k) | 16'(k + 5));
      rd(4'h1, 16'(k + 5));
      chk({10'h000, prog_control_o}, 16'(k + 5));
    end
    $display("programming error test done");
  endtask : t_prog

  task automatic t_path;
    logic [15:0] cfg [8] = '{16'h4000, 16'h2000, 16'h49E6, 16'h0064,
                             16'h4000, 16'h0000, 16'h4000, 16'h0000};
    for (int i = 0; i < 8; i++) begin
      i_sensor_programmer.write_reg(4'(i + 6), cfg[i]);
    end
    // Final trim is read back before the part would be locked; the lock sits elsewhere.
    rd(4'h8, 16'h49E6);
    @(posedge ref_clk_i) #1;
    sample_valid_i = 1'b1;
    first_field_channel_i = 16'sh03E8;
    second_field_channel_i = 16'sh07D0;
    junction_temperature_reading_i = 16'h83E8;
    @(posedge ref_clk_i) #1;
    sample_valid_i = 1'b0;
    chk(offset_poly_o, 16'(100 + 16384 * 1000 / 32768));
    chk({15'h0000, angle_valid_o}, 16'h0000);
    @(posedge ref_clk_i) #1;
    chk({15'h0000, angle_valid_o}, 16'h0001);
    chk(angle_first_o, 16'(1000 * 8192 / 16384 + 600 * 16384 / 32768));
    chk(angle_second_o, 16'((2000 + 1000 * 16384 / 32768) * 18918 / 16384));
    $display("signal path test done");
  endtask : t_path

  initial begin
    repeat (3) @(posedge ref_clk_i);
    #1 reset_n_i = 1'b1;
    t_reset;
    t_access;
    t_faults;
    t_prog;
    t_path;
    give_verdict;
  end
endmodule : sensor_diag_and_channel_trim_tb
